// *** ssr_pkg.sv ***
// Shared constants for the slave state checker and its master end.
// Assumes a single 100 MHz clock shared by both ends.
package ssr_pkg;
  // Requested-state encodings in the low nibble of the request word.
  localparam logic [3:0] REQ_INIT   = 4'h1;
  localparam logic [3:0] REQ_PREOP  = 4'h2;
  localparam logic [3:0] REQ_BOOT   = 4'h3;
  localparam logic [3:0] REQ_SAFEOP = 4'h4;
  localparam logic [3:0] REQ_OP     = 4'h8;
  // Error acknowledge flag in the request word and error indication position in the status byte.
  localparam int         ACK_BIT    = 4;
  localparam int         ERR_BIT    = 4;
  // Status codes.
  localparam logic [15:0] CODE_NONE   = 16'h0000;
  localparam logic [15:0] CODE_UNSPEC = 16'h0001;
  localparam logic [15:0] CODE_NOMEM  = 16'h0002;
  localparam logic [15:0] CODE_REV    = 16'h0004;
  localparam logic [15:0] CODE_TRANS  = 16'h0011;
  localparam logic [15:0] CODE_UNKN   = 16'h0012;
  localparam logic [15:0] CODE_NOBOOT = 16'h0013;
  localparam logic [15:0] CODE_FW     = 16'h0014;
  localparam logic [15:0] CODE_MBX    = 16'h0015;
  // Mailbox areas: 0 carries master-to-slave, 1 carries slave-to-master.
  localparam int MBX_AREAS = 2;
  // Master-end register offsets and reset values.
  localparam logic [3:0]  OFF_CTRL   = 4'h0;
  localparam logic [3:0]  OFF_STATUS = 4'h4;
  localparam logic [3:0]  OFF_MBX    = 4'h8;
  localparam logic [1:0]  RESP_OKAY  = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  localparam logic [31:0] RST_WORD   = 32'h0000_0000;

  // Device states; the wire code comes from state_code().
  typedef enum logic [2:0] {ST_INIT, ST_PREOP, ST_BOOT, ST_SAFEOP, ST_OP} ssr_state_t;

  // Mailbox area owner.
  typedef enum logic [1:0] {OWN_NONE, OWN_MASTER, OWN_LOCAL} ssr_owner_t;

  // Maps a state to its low-nibble code.
  function automatic logic [3:0] state_code(input ssr_state_t s);
    case (s)
      ST_INIT:   state_code = REQ_INIT;
      ST_PREOP:  state_code = REQ_PREOP;
      ST_BOOT:   state_code = REQ_BOOT;
      ST_SAFEOP: state_code = REQ_SAFEOP;
      ST_OP:     state_code = REQ_OP;
      default:   state_code = REQ_INIT;
    endcase
  endfunction : state_code
endpackage : ssr_pkg

// *** ssr_link_if.sv ***
// Link between the fieldbus master end and the slave state checker.
// Both ends run on the same clock; no crossing is needed.
`timescale 1ns/1ns
interface ssr_link_if;
  logic       req_valid;   // One-cycle pulse carrying a request word.
  logic [7:0] req_word;    // Low nibble state, bit 4 error acknowledge.
  logic [7:0] al_status;   // Current state code with error indication.
  logic [15:0] code;       // Latched status code.
  logic [1:0] mbx_req;     // Master wants a mailbox area.
  logic [1:0] mbx_gnt;     // Master owns a mailbox area.

  modport master (output req_valid, output req_word, output mbx_req,
                  input al_status, input code, input mbx_gnt);
  modport device (input req_valid, input req_word, input mbx_req,
                  output al_status, output code, output mbx_gnt);
endinterface : ssr_link_if

// *** ssr_device.sv ***
// Slave state checker: decodes state requests, accepts or rejects them,
// reports status with error indication, and guards two mailbox areas.
// Assumes the master end shares i_clk and pulses req_valid for one cycle.
//
// Our own choices: the address map and the AXI4-Lite register port.
`timescale 1ns/1ns
module ssr_device (
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  ssr_link_if.device      link,
  input  wire logic       i_boot_supported,
  input  wire logic       i_fault_unspec,
  input  wire logic       i_fault_nomem,
  input  wire logic       i_rev_bad,
  input  wire logic       i_fw_bad,
  input  wire logic       i_mbx_cfg_bad,
  input  wire logic [1:0] i_loc_mbx_req,
  output logic      [1:0] o_loc_mbx_gnt,
  output logic      [3:0] o_state,
  output logic            o_err
);

  ssr_pkg::ssr_state_t state_reg;
  ssr_pkg::ssr_state_t state_next;
  logic                err_reg;
  logic                err_next;
  logic [15:0]         code_reg;
  logic [15:0]         code_next;
  logic [3:0]          req_nib;
  logic                ack;
  ssr_pkg::ssr_state_t target;
  logic                known;
  ssr_pkg::ssr_owner_t owner_reg [ssr_pkg::MBX_AREAS];

  // Request word fields.
  assign req_nib = link.req_word[3:0];
  assign ack     = link.req_valid & link.req_word[ssr_pkg::ACK_BIT];

  // Decode the requested target state and whether the encoding is known.
  always_comb begin
    known  = 1'b1;
    target = ssr_pkg::ST_INIT;
    case (req_nib)
      ssr_pkg::REQ_INIT:   target = ssr_pkg::ST_INIT;
      ssr_pkg::REQ_PREOP:  target = ssr_pkg::ST_PREOP;
      ssr_pkg::REQ_BOOT:   target = ssr_pkg::ST_BOOT;
      ssr_pkg::REQ_SAFEOP: target = ssr_pkg::ST_SAFEOP;
      ssr_pkg::REQ_OP:     target = ssr_pkg::ST_OP;
      default:             known  = 1'b0;
    endcase
  end

  // Transition checker. The acknowledge is applied first so that a request
  // carrying it is judged on a clean slate; faults are applied last so that
  // an event in the acknowledging cycle is never lost.
  always_comb begin
    state_next = state_reg;
    err_next   = err_reg;
    code_next  = code_reg;
    if (ack) begin
      err_next  = 1'b0;
      code_next = ssr_pkg::CODE_NONE;
    end
    if (link.req_valid) begin
      if (!known) begin
        err_next  = 1'b1;
        code_next = ssr_pkg::CODE_UNKN;
      end else if (target == state_reg) begin
        state_next = state_reg;
      end else begin
        case (state_reg)
          ssr_pkg::ST_INIT: begin
            if (target == ssr_pkg::ST_PREOP) begin
              if (i_fw_bad) begin
                err_next  = 1'b1;
                code_next = ssr_pkg::CODE_FW;
              end else begin
                state_next = ssr_pkg::ST_PREOP;
              end
            end else if (target == ssr_pkg::ST_BOOT) begin
              if (!i_boot_supported) begin
                err_next  = 1'b1;
                code_next = ssr_pkg::CODE_NOBOOT;
              end else if (i_mbx_cfg_bad) begin
                err_next  = 1'b1;
                code_next = ssr_pkg::CODE_MBX;
              end else begin
                state_next = ssr_pkg::ST_BOOT;
              end
            end else begin
              err_next  = 1'b1;
              code_next = ssr_pkg::CODE_TRANS;
            end
          end
          ssr_pkg::ST_PREOP: begin
            if (target == ssr_pkg::ST_INIT) begin
              state_next = ssr_pkg::ST_INIT;
            end else if (target == ssr_pkg::ST_SAFEOP) begin
              if (i_rev_bad) begin
                err_next  = 1'b1;
                code_next = ssr_pkg::CODE_REV;
              end else begin
                state_next = ssr_pkg::ST_SAFEOP;
              end
            end else begin
              err_next  = 1'b1;
              code_next = ssr_pkg::CODE_TRANS;
            end
          end
          ssr_pkg::ST_BOOT: begin
            // Boot may only be left towards INIT.
            if (target == ssr_pkg::ST_INIT) begin
              state_next = ssr_pkg::ST_INIT;
            end else begin
              err_next  = 1'b1;
              code_next = ssr_pkg::CODE_TRANS;
            end
          end
          ssr_pkg::ST_SAFEOP: begin
            if (target == ssr_pkg::ST_BOOT) begin
              err_next  = 1'b1;
              code_next = ssr_pkg::CODE_TRANS;
            end else begin
              state_next = target;
            end
          end
          ssr_pkg::ST_OP: begin
            if (target == ssr_pkg::ST_BOOT) begin
              err_next  = 1'b1;
              code_next = ssr_pkg::CODE_TRANS;
            end else begin
              state_next = target;
            end
          end
          default: begin
            state_next = ssr_pkg::ST_INIT;
          end
        endcase
      end
    end
    // Application faults keep the state and win over an ack, so that a fault
    // raised in the acknowledging cycle is never wiped out by the master.
    if (i_fault_nomem) begin
      err_next  = 1'b1;
      code_next = ssr_pkg::CODE_NOMEM;
    end else if (i_fault_unspec) begin
      err_next  = 1'b1;
      code_next = ssr_pkg::CODE_UNSPEC;
    end
  end

  // State, error indication and status code registers.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg <= ssr_pkg::ST_INIT;
      err_reg   <= 1'b0;
      code_reg  <= ssr_pkg::CODE_NONE;
    end else begin
      state_reg <= state_next;
      err_reg   <= err_next;
      code_reg  <= code_next;
    end
  end

  // Registered status outputs; SAFEOP with error reads 0x14.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      link.al_status <= {3'h0, 1'b0, ssr_pkg::REQ_INIT};
      link.code      <= ssr_pkg::CODE_NONE;
      o_state        <= ssr_pkg::REQ_INIT;
      o_err          <= 1'b0;
    end else begin
      link.al_status <= {3'h0, err_next, ssr_pkg::state_code(state_next)};
      link.code      <= code_next;
      o_state        <= ssr_pkg::state_code(state_next);
      o_err          <= err_next;
    end
  end

  // Mailbox guard: an area belongs to one party until that party lets go.
  // The master wins a same-cycle tie; the local side simply retries.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int i = 0; i < ssr_pkg::MBX_AREAS; i++) begin
        owner_reg[i] <= ssr_pkg::OWN_NONE;
      end
    end else begin
      for (int i = 0; i < ssr_pkg::MBX_AREAS; i++) begin
        case (owner_reg[i])
          ssr_pkg::OWN_NONE: begin
            if (link.mbx_req[i]) begin
              owner_reg[i] <= ssr_pkg::OWN_MASTER;
            end else if (i_loc_mbx_req[i]) begin
              owner_reg[i] <= ssr_pkg::OWN_LOCAL;
            end
          end
          ssr_pkg::OWN_MASTER: begin
            if (!link.mbx_req[i]) begin
              owner_reg[i] <= ssr_pkg::OWN_NONE;
            end
          end
          ssr_pkg::OWN_LOCAL: begin
            if (!i_loc_mbx_req[i]) begin
              owner_reg[i] <= ssr_pkg::OWN_NONE;
            end
          end
          default: owner_reg[i] <= ssr_pkg::OWN_NONE;
        endcase
      end
    end
  end

  // Grants are registered copies of ownership, so both never rise together.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      link.mbx_gnt  <= 2'h0;
      o_loc_mbx_gnt <= 2'h0;
    end else begin
      for (int i = 0; i < ssr_pkg::MBX_AREAS; i++) begin
        link.mbx_gnt[i]  <= (owner_reg[i] == ssr_pkg::OWN_MASTER);
        o_loc_mbx_gnt[i] <= (owner_reg[i] == ssr_pkg::OWN_LOCAL);
      end
    end
  end

endmodule : ssr_device

// *** ssr_master.sv ***
// Fieldbus master end: software posts request words and mailbox access
// over AXI4-Lite; status from the slave is readable.
// Assumes the device end shares i_clk and one write and one read at a time.
`timescale 1ns/1ns
module ssr_master (
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  ssr_link_if.master       link,
  input  wire logic [3:0]  i_awaddr,
  input  wire logic        i_awvalid,
  output logic             o_awready,
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_wstrb,
  input  wire logic        i_wvalid,
  output logic             o_wready,
  output logic [1:0]       o_bresp,
  output logic             o_bvalid,
  input  wire logic        i_bready,
  input  wire logic [3:0]  i_araddr,
  input  wire logic        i_arvalid,
  output logic             o_arready,
  output logic [31:0]      o_rdata,
  output logic [1:0]       o_rresp,
  output logic             o_rvalid,
  input  wire logic        i_rready
);

  logic       aw_have_reg;
  logic [3:0] aw_addr_reg;
  logic       w_have_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic       do_write;

  // A write executes once both halves are held and no response is pending.
  assign do_write = aw_have_reg & w_have_reg & ~o_bvalid;

  // Address and data channels are taken independently, in either order.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      aw_have_reg <= 1'b0;
      aw_addr_reg <= 4'h0;
      w_have_reg  <= 1'b0;
      w_data_reg  <= ssr_pkg::RST_WORD;
      w_strb_reg  <= 4'h0;
      o_awready   <= 1'b1;
      o_wready    <= 1'b1;
    end else begin
      if (i_awvalid && o_awready) begin
        aw_have_reg <= 1'b1;
        aw_addr_reg <= i_awaddr;
        o_awready   <= 1'b0;
      end
      if (i_wvalid && o_wready) begin
        w_have_reg <= 1'b1;
        w_data_reg <= i_wdata;
        w_strb_reg <= i_wstrb;
        o_wready   <= 1'b0;
      end
      if (o_bvalid && i_bready) begin
        aw_have_reg <= 1'b0;
        w_have_reg  <= 1'b0;
        o_awready   <= 1'b1;
        o_wready    <= 1'b1;
      end
    end
  end

  // Register effects and the write response. A control write with strobe bit 0 set sends one
  // request pulse; the word is forwarded unchecked, and the slave rejects an undefined encoding.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_bvalid       <= 1'b0;
      o_bresp        <= ssr_pkg::RESP_OKAY;
      link.req_valid <= 1'b0;
      link.req_word  <= 8'h00;
      link.mbx_req   <= 2'h0;
    end else begin
      link.req_valid <= 1'b0;
      if (o_bvalid && i_bready) begin
        o_bvalid <= 1'b0;
      end else if (do_write) begin
        o_bvalid <= 1'b1;
        o_bresp  <= ssr_pkg::RESP_OKAY;
        case (aw_addr_reg)
          ssr_pkg::OFF_CTRL: begin
            if (w_strb_reg[0]) begin
              link.req_valid <= 1'b1;
              link.req_word  <= w_data_reg[7:0];
            end
          end
          ssr_pkg::OFF_MBX: begin
            if (w_strb_reg[0]) begin
              link.mbx_req <= w_data_reg[1:0];
            end
          end
          ssr_pkg::OFF_STATUS: o_bresp <= ssr_pkg::RESP_OKAY;
          default: o_bresp <= ssr_pkg::RESP_SLVERR;
        endcase
      end
    end
  end

  // Read channel: answer one cycle after the address is taken.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_arready <= 1'b1;
      o_rvalid  <= 1'b0;
      o_rdata   <= ssr_pkg::RST_WORD;
      o_rresp   <= ssr_pkg::RESP_OKAY;
    end else begin
      if (i_arvalid && o_arready) begin
        o_arready <= 1'b0;
        o_rvalid  <= 1'b1;
        o_rresp   <= ssr_pkg::RESP_OKAY;
        case (i_araddr)
          ssr_pkg::OFF_CTRL:   o_rdata <= {24'h0, link.req_word};
          ssr_pkg::OFF_STATUS: o_rdata <= {link.code, 8'h00, link.al_status};
          ssr_pkg::OFF_MBX:    o_rdata <= {28'h0, link.mbx_gnt, link.mbx_req};
          default: begin
            o_rdata <= ssr_pkg::RST_WORD;
            o_rresp <= ssr_pkg::RESP_SLVERR;
          end
        endcase
      end else if (o_rvalid && i_rready) begin
        o_rvalid  <= 1'b0;
        o_arready <= 1'b1;
      end
    end
  end

endmodule : ssr_master

// *** ssr_link_sva.sv ***
// Concurrent checks on the link between the master end and the slave checker.
// Assumes one clock and an active-low asynchronous reset shared by both ends.
`timescale 1ns/1ns
module ssr_link_sva (
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_req_valid,
  input  wire logic [7:0]  i_req_word,
  input  wire logic [7:0]  i_al_status,
  input  wire logic [15:0] i_code,
  input  wire logic [1:0]  i_mbx_req,
  input  wire logic [1:0]  i_mbx_gnt
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);

  // A request for nibble n made while the reported state is c.
  sequence s_step(logic [3:0] c, logic [3:0] n);
    i_req_valid && i_al_status[3:0] == c && i_req_word[3:0] == n;
  endsequence
  // A local fault may override the code of that cycle, so both fault codes are let through.
  sequence s_reject(logic [15:0] k, logic [3:0] c);
    (i_code inside {k, 16'h0001, 16'h0002}) && i_al_status[4] && i_al_status[3:0] == c;
  endsequence

  a_state_codes: assert property (
    i_al_status[3:0] inside {4'h1, 4'h2, 4'h3, 4'h4, 4'h8} && i_al_status[7:5] == 3'h0)
    else $error("bad state code");
  a_code_flags: assert property (i_code != 16'h0000 |-> i_al_status[4])
    else $error("code without error flag");
  a_err_sticky: assert property (
    i_al_status[4] && !(i_req_valid && i_req_word[4]) |=> i_al_status[4])
    else $error("error flag lost");
  a_jump_reject: assert property (s_step(4'h1, 4'h8) |=> s_reject(16'h0011, 4'h1))
    else $error("jump accepted");
  a_boot_reject: assert property (
    i_req_valid && i_req_word[3:0] == 4'h3 && (i_al_status[3:0] inside {4'h2, 4'h4, 4'h8})
    |=> (i_code inside {16'h0011, 16'h0001, 16'h0002}) && i_al_status[4]
    && $stable(i_al_status[3:0]))
    else $error("boot from upper state");
  a_unknown_req: assert property (
    i_req_valid && !(i_req_word[3:0] inside {4'h1, 4'h2, 4'h3, 4'h4, 4'h8})
    |=> (i_code inside {16'h0012, 16'h0001, 16'h0002}) && i_al_status[4]
    && $stable(i_al_status[3:0]))
    else $error("unknown request taken");
  a_ack_init: assert property (s_step(4'h1, 4'h1) ##0 i_req_word[4]
    |=> (i_code inside {16'h0000, 16'h0001, 16'h0002}) && i_al_status[3:0] == 4'h1)
    else $error("ack did not clear");
  a_rev_step: assert property (s_step(4'h2, 4'h4)
    |=> i_al_status[3:0] == 4'h4 || ((i_code inside {16'h0004, 16'h0001, 16'h0002})
    && i_al_status[4]))
    else $error("bad preop step");
  // A boot request from INIT either succeeds or stays in INIT flagged with the no-boot, mailbox or a fault code.
  a_boot_step: assert property (s_step(4'h1, 4'h3)
    |=> i_al_status[3:0] == 4'h3 || (i_al_status[4] && i_al_status[3:0] == 4'h1
    && (i_code inside {16'h0013, 16'h0015, 16'h0001, 16'h0002})))
    else $error("bad boot step");
  a_gnt_held: assert property (
    (i_mbx_gnt & ~($past(i_mbx_req) | $past(i_mbx_req, 2))) == 2'b00)
    else $error("grant without request");
endmodule : ssr_link_sva

// *** slave_state_error_reporting_test.sv ***
// Testbench joining the master end and the slave checker through the link.
// Assumes ssr_pkg, ssr_link_if, ssr_device, ssr_master and the checker are compiled first.
`timescale 1ns/1ns
module slave_state_error_reporting_test;
  logic        i_clk;
  logic        i_rst_n;
  logic [3:0]  awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata;
  logic        awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, loc_req, loc_gnt, r;
  logic        boot_ok, f_uns, f_mem, rev_bad, fw_bad, mbx_bad, err;
  logic [3:0]  state;
  logic [31:0] d;
  int          n_mismatch = 0;
  int          check_count = 0;

  ssr_link_if ssr_link_if_inst ();
  ssr_device ssr_device_inst (.i_clk(i_clk), .i_rst_n(i_rst_n), .link(ssr_link_if_inst),
    .i_boot_supported(boot_ok), .i_fault_unspec(f_uns), .i_fault_nomem(f_mem),
    .i_rev_bad(rev_bad), .i_fw_bad(fw_bad), .i_mbx_cfg_bad(mbx_bad),
    .i_loc_mbx_req(loc_req), .o_loc_mbx_gnt(loc_gnt), .o_state(state), .o_err(err));
  ssr_master ssr_master_inst (.i_clk(i_clk), .i_rst_n(i_rst_n), .link(ssr_link_if_inst),
    .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata),
    .i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp),
    .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid),
    .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid),
    .i_rready(rready));
  ssr_link_sva ssr_link_sva_inst (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_req_valid(ssr_link_if_inst.req_valid), .i_req_word(ssr_link_if_inst.req_word),
    .i_al_status(ssr_link_if_inst.al_status), .i_code(ssr_link_if_inst.code),
    .i_mbx_req(ssr_link_if_inst.mbx_req), .i_mbx_gnt(ssr_link_if_inst.mbx_gnt));

  // Free-running 100 MHz clock.
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  // Prints the counts and the verdict, then ends the run.
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : complete_run

  // Compares one value; case inequality keeps an unknown from passing.
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // One write; both channels offered together and each dropped once taken.
  task automatic wr(input logic [3:0] a, input logic [31:0] v, output logic [1:0] rs);
    @(posedge i_clk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge i_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        rs = bresp;
        bready <= 1'b0;
        break;
      end
    end
  endtask : wr

  // One read; rready is held until the data are seen.
  task automatic rd(input logic [3:0] a, output logic [31:0] v, output logic [1:0] rs);
    @(posedge i_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge i_clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        v = rdata;
        rs = rresp;
        rready <= 1'b0;
        break;
      end
    end
  endtask : rd

  // Status word is {code, 8'h00, state code with error flag}.
  task automatic st(input logic [31:0] e);
    rd(ssr_pkg::OFF_STATUS, d, r);
    chk("status", e, d);
  endtask : st

  // Sends a request word and checks the status that follows.
  task automatic rs(input logic [7:0] w, input logic [31:0] e);
    wr(ssr_pkg::OFF_CTRL, {24'h000000, w}, r);
    st(e);
  endtask : rs

  // A fault input raised for a single cycle.
  task automatic pulse(input bit mem);
    @(posedge i_clk);
    if (mem) f_mem <= 1'b1;
    else f_uns <= 1'b1;
    @(posedge i_clk);
    f_mem <= 1'b0;
    f_uns <= 1'b0;
  endtask : pulse

  // A hang is cut short well beyond the under two hundred cycles the tests need.
  initial begin
    repeat (20000) @(posedge i_clk);
    n_mismatch++;
    complete_run();
  end

  // Main sequence: rejection paths out of INIT and PREOP, faults and acknowledge, then mailbox, unmapped access and reset.
  initial begin
    i_rst_n = 1'b0;
    {awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = '0;
    {boot_ok, f_uns, f_mem, rev_bad, fw_bad, mbx_bad, loc_req} = '0;
    wstrb = 4'hF;
    repeat (5) @(posedge i_clk);
    i_rst_n <= 1'b1;
    st(32'h0000_0001);
    rs(8'h08, 32'h0011_0011);
    rs(8'h05, 32'h0012_0011);
    rs(8'h11, 32'h0000_0001);
    rs(8'h03, 32'h0013_0011);
    rs(8'h11, 32'h0000_0001);
    boot_ok <= 1'b1;
    mbx_bad <= 1'b1;
    rs(8'h03, 32'h0015_0011);
    mbx_bad <= 1'b0;
    fw_bad <= 1'b1;
    rs(8'h12, 32'h0014_0011);
    fw_bad <= 1'b0;
    rs(8'h12, 32'h0000_0002);
    rs(8'h03, 32'h0011_0012);
    rev_bad <= 1'b1;
    rs(8'h14, 32'h0004_0012);
    rev_bad <= 1'b0;
    rs(8'h14, 32'h0000_0004);
    pulse(1'b0);
    st(32'h0001_0014);
    rs(8'h04, 32'h0001_0014);
    rs(8'h14, 32'h0000_0004);
    pulse(1'b1);
    st(32'h0002_0014);
    rs(8'h18, 32'h0000_0008);
    chk("state pin", 32'h8, {28'h0, state});
    chk("err pin", 32'h0, {31'h0, err});
    // The control word reads back as last written.
    rd(ssr_pkg::OFF_CTRL, d, r);
    chk("ctrl word", 32'h18, d);
    // A control write without the low byte strobe must send no request.
    wstrb <= 4'hE;
    wr(ssr_pkg::OFF_CTRL, 32'h01, r);
    wstrb <= 4'hF;
    st(32'h0000_0008);
    // Local side takes the in-mailbox first, so the master must wait for it.
    loc_req <= 2'b10;
    repeat (3) @(posedge i_clk);
    chk("local grant", 32'h2, {30'h0, loc_gnt});
    wr(ssr_pkg::OFF_MBX, 32'h3, r);
    repeat (3) @(posedge i_clk);
    rd(ssr_pkg::OFF_MBX, d, r);
    chk("mailbox", 32'h7, d);
    chk("local grant", 32'h2, {30'h0, loc_gnt});
    loc_req <= 2'b00;
    repeat (4) @(posedge i_clk);
    rd(ssr_pkg::OFF_MBX, d, r);
    chk("mailbox", 32'hF, d);
    wr(ssr_pkg::OFF_MBX, 32'h0, r);
    // Unmapped offset answers with an error and no data.
    wr(4'hC, 32'hFF, r);
    chk("unmapped bresp", {30'h0, ssr_pkg::RESP_SLVERR}, {30'h0, r});
    rd(4'hC, d, r);
    chk("unmapped rdata", 32'h0, d);
    chk("unmapped rresp", {30'h0, ssr_pkg::RESP_SLVERR}, {30'h0, r});
    // A reset in mid-run must bring the slave back to INIT with a clean status.
    i_rst_n <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_rst_n <= 1'b1;
    st(32'h0000_0001);
    chk("state pin", 32'h1, {28'h0, state});
    complete_run();
  end
endmodule : slave_state_error_reporting_test
